/* design/wcpi_process_image.sv */
/*
  Process image of a single bridge-sensor weighing channel: command byte handling,
  tare, adjustment, zero point (reference point command only acknowledged), input freeze, filter, self-calibration and status.
  Assumes raw ADC samples as strobes on core_clk, a host that writes the command byte
  as a level and holds each bit until acknowledged, and parametrisation as static inputs.
*/
`timescale 1ns/1ps
module wcpi_process_image
  import wcpi_pkg::*;
#(
  parameter int HOLD_W = 16,
  parameter int CAL_W = 24,
  parameter int FILT_SHIFT = 2,
  parameter int CAL_SETTLE = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] host_command_byte,
  input wire logic adc_valid,
  input wire logic signed [31:0] adc_sample,
  input wire logic adc_is_reference,
  input wire logic [HOLD_W-1:0] steady_hold_time,
  input wire logic [31:0] steady_tolerance_band,
  input wire logic [CAL_W-1:0] recalibration_period,
  input wire logic adj_store_fail,
  output logic cal_ref_select,
  output logic cal_ref_enable,
  output wcpi_input_t input_area,
  output logic [31:0] input_area_bytes,
  output logic [15:0] canopen_object_index_in,
  output logic [15:0] canopen_object_index_out
);
  logic [7:0] cmd_prev_reg;
  logic [7:0] cmd_rise;
  logic signed [31:0] tare_reg;
  logic signed [31:0] offset_reg;
  logic signed [31:0] gain_reg;
  logic signed [31:0] zero_reg;
  logic signed [31:0] span_reg;
  logic signed [31:0] filt_reg;
  logic signed [31:0] corrected;
  logic signed [63:0] scaled;
  logic signed [31:0] weight_reg;
  logic filt_valid_reg;
  logic adj_valid_reg;
  logic adj_ack_reg;
  logic adj_err_reg;
  logic tare_ack_reg;
  logic zero_ack_reg;
  logic steady;
  logic tick;
  logic [$clog2(WCPI_TICK_CYCLES)-1:0] tick_cnt_reg;
  logic [CAL_W-1:0] cal_timer_reg;
  logic [$clog2(CAL_SETTLE+1)-1:0] settle_reg;
  logic signed [31:0] cal_lo_reg;
  wcpi_cal_state_t cal_state_reg;
  logic calibrating;
  logic sample_ok;

  function automatic logic signed [31:0] wcpi_sat(input logic signed [63:0] v);
    if (v > 64'sh0000_0000_7FFF_FFFF) begin
      return 32'sh7FFF_FFFF;
    end else if (v < -64'sh0000_0000_8000_0000) begin
      return 32'sh8000_0000;
    end
    return v[31:0];
  endfunction : wcpi_sat

  assign cmd_rise = host_command_byte & ~cmd_prev_reg;
  assign calibrating = cal_state_reg != WCPI_CAL_IDLE;
  // Freeze and calibration both keep samples away from the filter
  assign sample_ok = adc_valid && !host_command_byte[WCPI_CMD_FREEZE] && !calibrating;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_prev_reg <= WCPI_CMD_RESET;
    end else begin
      cmd_prev_reg <= host_command_byte;
    end
  end

  // 1 us tick for the steady and calibration timers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end
  assign tick = tick_cnt_reg == ($clog2(WCPI_TICK_CYCLES))'(WCPI_TICK_CYCLES - 1);

  // First-order IIR filter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      filt_reg <= '0;
      filt_valid_reg <= 1'b0;
    end else begin
      filt_valid_reg <= sample_ok;
      if (sample_ok) begin
        filt_reg <= filt_reg + ((adc_sample - filt_reg) >>> FILT_SHIFT);
      end
    end
  end

  // Self-calibration: zero reference, then full reference; offset and gain are computed on its last sample, and CALC only returns to idle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cal_state_reg <= WCPI_CAL_IDLE;
      cal_timer_reg <= '0;
      settle_reg <= '0;
      cal_lo_reg <= '0;
      offset_reg <= '0;
      gain_reg <= WCPI_GAIN_UNITY;
    end else begin
      case (cal_state_reg)
        WCPI_CAL_IDLE: begin
          settle_reg <= '0;
          if (recalibration_period != '0 && tick) begin
            if (cal_timer_reg >= recalibration_period - 1'b1) begin
              cal_timer_reg <= '0;
              cal_state_reg <= WCPI_CAL_ZERO;
            end else begin
              cal_timer_reg <= cal_timer_reg + 1'b1;
            end
          end
        end
        WCPI_CAL_ZERO: begin
          if (adc_valid && adc_is_reference) begin
            if (settle_reg == ($clog2(CAL_SETTLE+1))'(CAL_SETTLE)) begin
              cal_lo_reg <= adc_sample;
              settle_reg <= '0;
              cal_state_reg <= WCPI_CAL_FULL;
            end else begin
              settle_reg <= settle_reg + 1'b1;
            end
          end
        end
        WCPI_CAL_FULL: begin
          if (adc_valid && adc_is_reference) begin
            if (settle_reg == ($clog2(CAL_SETTLE+1))'(CAL_SETTLE)) begin
              offset_reg <= cal_lo_reg;
              // Gain: unity span over measured span, one cycle of division
              gain_reg <= (adc_sample != cal_lo_reg)
                  ? 32'((64'sd1 <<< (2 * WCPI_GAIN_SHIFT)) / 64'(adc_sample - cal_lo_reg))
                  : WCPI_GAIN_UNITY;
              cal_state_reg <= WCPI_CAL_CALC;
            end else begin
              settle_reg <= settle_reg + 1'b1;
            end
          end
        end
        WCPI_CAL_CALC: begin
          cal_state_reg <= WCPI_CAL_IDLE;
        end
        default: begin
          cal_state_reg <= WCPI_CAL_IDLE;
        end
      endcase
    end
  end
  assign cal_ref_enable = calibrating;
  assign cal_ref_select = cal_state_reg == WCPI_CAL_FULL;

  // Offset and gain correction
  assign corrected = wcpi_sat(64'(filt_reg) - 64'(offset_reg));
  assign scaled = (64'(corrected) * 64'(gain_reg)) >>> WCPI_GAIN_SHIFT;

  // Tare
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tare_reg <= WCPI_TARE_RESET;
    end else if (cmd_rise[WCPI_CMD_TARE_DEL]) begin
      tare_reg <= WCPI_TARE_RESET;
    end else if (cmd_rise[WCPI_CMD_TARE_SET]) begin
      tare_reg <= wcpi_sat(scaled - 64'(zero_reg));
    end
  end

  // Zero point user adjustment (the reference point command is only acknowledged); store/delete of adjustment data
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      zero_reg <= '0;
      span_reg <= WCPI_GAIN_UNITY;
      adj_valid_reg <= 1'b0;
    end else begin
      if (cmd_rise[WCPI_CMD_ZERO_SET]) begin
        zero_reg <= wcpi_sat(scaled);
      end
      if (cmd_rise[WCPI_CMD_ADJ_DEL] && !adj_store_fail) begin
        zero_reg <= '0;
        span_reg <= WCPI_GAIN_UNITY;
        adj_valid_reg <= 1'b0;
      end else if (cmd_rise[WCPI_CMD_ADJ_STORE] && !adj_store_fail) begin
        adj_valid_reg <= 1'b1;
      end
    end
  end

  // Acknowledge flags: set on command, held while the command bit stays set
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tare_ack_reg <= 1'b0;
      adj_ack_reg <= 1'b0;
      adj_err_reg <= 1'b0;
      zero_ack_reg <= 1'b0;
    end else begin
      tare_ack_reg <= |(host_command_byte & 8'h18);
      adj_ack_reg <= |(host_command_byte & 8'h06);
      zero_ack_reg <= |(host_command_byte & 8'hC0);
      if (|(cmd_rise & 8'h06) && adj_store_fail) begin
        adj_err_reg <= 1'b1;
      end else if (!(|(host_command_byte & 8'h06))) begin
        adj_err_reg <= 1'b0;
      end
    end
  end

  // Gross minus zero minus tare, registered for the input area
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      weight_reg <= '0;
    end else begin
      weight_reg <= wcpi_sat(scaled - 64'(zero_reg) - 64'(tare_reg));
    end
  end

  wcpi_steady #(
    .HOLD_W(HOLD_W)
  ) u_steady (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .tick(tick),
    .sample_valid(filt_valid_reg),
    .sample(weight_reg),
    .tolerance(steady_tolerance_band),
    .hold_time(steady_hold_time),
    .steady(steady)
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      input_area.weight <= '0;
      input_area.status <= WCPI_STATUS_RESET;
    end else begin
      input_area.weight <= weight_reg;
      input_area.status[WCPI_ST_FREEZE] <= host_command_byte[WCPI_CMD_FREEZE];
      input_area.status[WCPI_ST_STEADY] <= steady;
      input_area.status[WCPI_ST_CAL] <= calibrating;
      input_area.status[WCPI_ST_TARE] <= tare_ack_reg;
      input_area.status[WCPI_ST_ADJ_ERR] <= adj_err_reg;
      input_area.status[WCPI_ST_ADJ] <= adj_ack_reg;
      input_area.status[6] <= 1'b0;
      input_area.status[WCPI_ST_ZERO] <= zero_ack_reg;
    end
  end

  // Byte 0 carries bits 31..24, most significant first
  assign input_area_bytes = {input_area.weight[31:24], input_area.weight[23:16],
                             input_area.weight[15:8], input_area.weight[7:0]};
  assign canopen_object_index_in = WCPI_IDX_INPUT;
  assign canopen_object_index_out = WCPI_IDX_OUTPUT;
endmodule : wcpi_process_image

/* design/wcpi_steady.sv */
/*
  Steady-state detector: compares each sample with a reference and counts microsecond ticks.
  Assumes samples arrive as one-cycle strobes on core_clk and a 1 us tick from the top.
*/
`timescale 1ns/1ps
module wcpi_steady
  import wcpi_pkg::*;
#(
  parameter int HOLD_W = 16
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic sample_valid,
  input wire logic signed [31:0] sample,
  input wire logic [31:0] tolerance,
  input wire logic [HOLD_W-1:0] hold_time,
  output logic steady
);
  logic signed [31:0] ref_reg;
  logic [HOLD_W-1:0] hold_cnt_reg;
  logic [32:0] diff;
  logic in_band;

  assign diff = (sample >= ref_reg) ? ({sample[31], sample} - {ref_reg[31], ref_reg})
                                    : ({ref_reg[31], ref_reg} - {sample[31], sample});
  assign in_band = diff <= {1'b0, tolerance};

  // Reference follows the last sample that left the band
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_reg <= '0;
    end else if (sample_valid && !in_band) begin
      ref_reg <= sample;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt_reg <= '0;
    end else if (sample_valid && !in_band) begin
      hold_cnt_reg <= '0;
    end else if (tick && hold_cnt_reg <= hold_time && !(&hold_cnt_reg)) begin
      hold_cnt_reg <= hold_cnt_reg + 1'b1;
    end
  end

  // Strictly longer than the hold time; leaving the band clears at once
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      steady <= 1'b0;
    end else if (sample_valid && !in_band) begin
      steady <= 1'b0;
    end else begin
      steady <= hold_cnt_reg > hold_time;
    end
  end
endmodule : wcpi_steady

/* inc/wcpi_pkg.sv */
/*
  Constants and types of the weigh-cell process image: status and command bit positions,
  register offsets, object indices, parameter defaults.
  Assumes one 125 MHz clock and a host that writes the command byte and reads the input area.
*/
package wcpi_pkg;
  // Input area and command byte offsets
  localparam logic [1:0] WCPI_OFS_WEIGHT = 2'h0;
  localparam logic [1:0] WCPI_OFS_STATUS = 2'h3;
  localparam logic [1:0] WCPI_OFS_CMD = 2'h0;
  // CANopen object indices
  localparam logic [15:0] WCPI_IDX_INPUT = 16'h5470;
  localparam logic [15:0] WCPI_IDX_STATUS = 16'h5471;
  localparam logic [15:0] WCPI_IDX_OUTPUT = 16'h5670;
  // Status bits
  localparam int WCPI_ST_FREEZE = 0;
  localparam int WCPI_ST_STEADY = 1;
  localparam int WCPI_ST_CAL = 2;
  localparam int WCPI_ST_TARE = 3;
  localparam int WCPI_ST_ADJ_ERR = 4;
  localparam int WCPI_ST_ADJ = 5;
  localparam int WCPI_ST_ZERO = 7;
  // Command bits
  localparam int WCPI_CMD_FREEZE = 0;
  localparam int WCPI_CMD_ADJ_STORE = 1;
  localparam int WCPI_CMD_ADJ_DEL = 2;
  localparam int WCPI_CMD_TARE_SET = 3;
  localparam int WCPI_CMD_TARE_DEL = 4;
  localparam int WCPI_CMD_ZERO_SET = 6;
  localparam int WCPI_CMD_REF_SET = 7;
  localparam logic [7:0] WCPI_CMD_RESET = 8'h00;
  localparam logic [7:0] WCPI_STATUS_RESET = 8'h00;
  localparam logic [31:0] WCPI_TARE_RESET = 32'h0000_0000;
  localparam logic [31:0] WCPI_GAIN_UNITY = 32'h0001_0000;
  localparam int WCPI_GAIN_SHIFT = 16;
  localparam int WCPI_CLK_MHZ = 125;
  localparam int WCPI_TICK_US = 1;
  localparam int WCPI_TICK_CYCLES = WCPI_TICK_US * WCPI_CLK_MHZ;

  typedef struct packed {
    logic [31:0] weight;
    logic [7:0] status;
  } wcpi_input_t;

  typedef enum logic [1:0] {
    WCPI_CAL_IDLE = 2'b00,
    WCPI_CAL_ZERO = 2'b01,
    WCPI_CAL_FULL = 2'b10,
    WCPI_CAL_CALC = 2'b11
  } wcpi_cal_state_t;
endpackage : wcpi_pkg

/* testbench/tb_weigh_cell_process_image.sv */
/* Self-checking bench of the weigh-cell process image.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module tb_weigh_cell_process_image;
  import wcpi_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic adc_valid = 1'b0;
  logic adc_is_reference = 1'b0;
  logic adj_store_fail = 1'b0;
  logic cal_sel, cal_en;
  logic [7:0] cmd_req = 8'h00;
  logic [7:0] cmd;
  logic signed [31:0] adc_sample = 32'h0000_0000;
  logic [15:0] hold_t = 16'h0002;
  logic [31:0] tol = 32'h0000_0010;
  logic [23:0] period = 24'h00_0000;
  wcpi_input_t ia;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;

  wcpi_process_image #(.CAL_SETTLE(1)) DUT (.core_clk(core_clk), .reset_n(reset_n),
    .host_command_byte(cmd), .adc_valid(adc_valid), .adc_sample(adc_sample),
    .adc_is_reference(adc_is_reference), .steady_hold_time(hold_t),
    .steady_tolerance_band(tol), .recalibration_period(period),
    .adj_store_fail(adj_store_fail), .cal_ref_select(cal_sel), .cal_ref_enable(cal_en),
    .input_area(ia), .input_area_bytes(), .canopen_object_index_in(),
    .canopen_object_index_out());
  wcpi_host_model u_host (.core_clk(core_clk), .reset_n(reset_n), .cmd_req(cmd_req),
    .status(ia.status), .host_command_byte(cmd));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // Hang guard: whole run is a few thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk

  task automatic feed(input int v, input int n);
    repeat (n) begin
      adc_valid <= 1'b1;
      adc_sample <= v;
      @(posedge core_clk);
      adc_valid <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask : feed

  function automatic logic near(input int e);
    int d;
    d = $signed(ia.weight) - e;
    return d > -16 && d < 16;
  endfunction : near

  task automatic wait_st(input int b, input logic v);
    for (int i = 0; i < 20 && ia.status[b] !== v; i++) @(posedge core_clk);
    chk(ia.status[b] === v, "status bit did not reach level");
  endtask : wait_st

  task automatic t_acks();
    int cb[7] = '{0, 1, 2, 3, 4, 6, 7};
    int sb[7] = '{0, 5, 5, 3, 3, 7, 7};
    foreach (cb[i]) begin
      cmd_req <= 8'h01 << cb[i];
      wait_st(sb[i], 1'b1);
      repeat (4) @(posedge core_clk);
      chk((ia.status & 8'hF9) === (8'h01 << sb[i]), "ack wrong or not held");
      cmd_req <= 8'h00;
      wait_st(sb[i], 1'b0);
    end
    cmd_req <= 8'h20;
    repeat (6) @(posedge core_clk);
    chk((ia.status & 8'hF9) === 8'h00, "reserved command acknowledged");
    cmd_req <= 8'h00;
  endtask : t_acks

  task automatic t_tare();
    feed(32'h0000_03E8, 40);
    chk(near(32'h0000_03E8), "weight not settled");
    cmd_req <= 8'h08;
    wait_st(3, 1'b1);
    cmd_req <= 8'h00;
    feed(32'h0000_0384, 40);
    chk(near(32'hFFFF_FF9C) && ia.weight[31] === 1'b1, "tare not subtracted");
    cmd_req <= 8'h10;
    wait_st(3, 1'b1);
    cmd_req <= 8'h00;
    feed(32'h0000_0384, 20);
    chk(near(32'h0000_0384), "tare not deleted");
  endtask : t_tare

  task automatic t_freeze();
    cmd_req <= 8'h01;
    wait_st(0, 1'b1);
    feed(32'h0000_1388, 20);
    chk(near(32'h0000_0384), "frozen weight moved");
    cmd_req <= 8'h00;
    wait_st(0, 1'b0);
    feed(32'h0000_1388, 40);
    chk(near(32'h0000_1388), "weight stuck after freeze");
  endtask : t_freeze

  task automatic t_adj_err();
    adj_store_fail <= 1'b1;
    cmd_req <= 8'h02;
    wait_st(4, 1'b1);
    adj_store_fail <= 1'b0;
    cmd_req <= 8'h00;
    wait_st(4, 1'b0);
    cmd_req <= 8'h04;
    wait_st(5, 1'b1);
    chk(ia.status[4] === 1'b0, "false adjustment error");
    cmd_req <= 8'h00;
  endtask : t_adj_err

  task automatic t_steady();
    feed(32'h0001_0000, 2);
    chk(ia.status[1] === 1'b0, "steady kept after band exit");
    feed(32'h0001_0000, 20);
    chk(ia.status[1] === 1'b0, "steady before hold time");
    feed(32'h0001_0000, 200);
    chk(ia.status[1] === 1'b1, "steady not reached");
    feed(32'h0002_0000, 2);
    chk(ia.status[1] === 1'b0, "steady kept after jump");
  endtask : t_steady

  task automatic t_cal();
    logic seen = 1'b0;
    logic done = 1'b0;
    adc_is_reference <= 1'b1;
    period <= 24'h00_0003;
    for (int i = 0; i < 600; i++) begin
      if (ia.status[2] === 1'b1) seen = 1'b1;
      if (seen && ia.status[2] === 1'b0) done = 1'b1;
      feed(cal_sel ? 32'h0001_0000 : 32'h0000_0000, 1);
    end
    chk(seen, "calibration never ran");
    chk(done, "calibration never finished");
  endtask : t_cal

  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    chk(ia === '0, "outputs not clear after reset");
    t_acks();
    t_tare();
    t_freeze();
    t_adj_err();
    t_steady();
    t_cal();
    close_out();
  end
endmodule : tb_weigh_cell_process_image

/* testbench/wcpi_host_model.sv */
/* Host side model: turns bench requests into the command byte.
   Assumes the status byte of the process image is fed back. */
`timescale 1ns/1ps
module wcpi_host_model
  import wcpi_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] cmd_req,
  input wire logic [7:0] status,
  output logic [7:0] host_command_byte
);
  logic [7:0] ack;
  logic [7:0] cmd_reg;
  assign ack = {status[7], status[7], 1'b0, status[3], status[3], status[5], status[5], status[0]};
  assign host_command_byte = cmd_reg;
  // Early release still held until acknowledged; reserved bit never held
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_reg <= WCPI_CMD_RESET;
    end else begin
      cmd_reg <= cmd_req | (cmd_reg & ~ack & 8'hDF);
    end
  end
endmodule : wcpi_host_model

/* testbench/wcpi_process_image_chk.sv */
/* Port checker for the weigh-cell process image.
   Assumes the host model drives the command byte and one clock domain. */
`timescale 1ns/1ps
module wcpi_chk
  import wcpi_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] host_command_byte,
  input wire logic cal_ref_enable,
  input wire wcpi_input_t input_area,
  input wire logic [31:0] input_area_bytes,
  input wire logic [15:0] canopen_object_index_in,
  input wire logic [15:0] canopen_object_index_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [7:0] st;
  assign st = input_area.status;
  sequence zero_held;
    (host_command_byte[6] || host_command_byte[7]) [*3];
  endsequence
  sequence adj_rise;
    $rose(host_command_byte[1] || host_command_byte[2]);
  endsequence
  freeze_follow_a: assert property (st[0] == $past(host_command_byte[0]))
    else $error("freeze flag does not follow command");
  tare_ack_a: assert property (st[3] == $past(host_command_byte[3] | host_command_byte[4], 2))
    else $error("tare flag out of step with command");
  adj_ack_a: assert property (adj_rise |-> ##2 st[5])
    else $error("adjustment flag missing");
  adj_drop_a: assert property ($fell(host_command_byte[1] || host_command_byte[2]) |-> ##2 !st[5])
    else $error("adjustment flag kept after release");
  zero_ack_a: assert property (zero_held |-> st[7])
    else $error("zero point flag missing");
  reserved_zero_a: assert property (st[6] == 1'b0)
    else $error("reserved status bit set");
  index_const_a: assert property (canopen_object_index_in == WCPI_IDX_INPUT && canopen_object_index_out == WCPI_IDX_OUTPUT)
    else $error("object index wrong");
  byte_order_a: assert property (input_area_bytes == input_area.weight)
    else $error("byte image differs from weight");
  cal_flag_a: assert property (cal_ref_enable [*2] |-> st[2])
    else $error("calibration flag low while calibrating");
endmodule : wcpi_chk

bind wcpi_process_image wcpi_chk u_chk (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .host_command_byte(host_command_byte),
  .cal_ref_enable(cal_ref_enable),
  .input_area(input_area),
  .input_area_bytes(input_area_bytes),
  .canopen_object_index_in(canopen_object_index_in),
  .canopen_object_index_out(canopen_object_index_out)
);
